//--- sssr_pkg.sv
// package: constants, types and structs for the status summary block
package sssr_pkg;
   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int SSSR_EVT_W = 16;
   localparam int SSSR_STD_W = 8;
   localparam int SSSR_NUM_SETS = 10;

   // ----------------------------------------------------------------
   // status byte field positions
   // ----------------------------------------------------------------
   localparam int SSSR_BIT_MEAS = 0;
   localparam int SSSR_BIT_UNUSED = 1;
   localparam int SSSR_BIT_ERR = 2;
   localparam int SSSR_BIT_QUES = 3;
   localparam int SSSR_BIT_MSG = 4;
   localparam int SSSR_BIT_STD = 5;
   localparam int SSSR_BIT_RQS = 6;
   localparam int SSSR_BIT_OPER = 7;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] SSSR_EVT_RST = 16'h0000;
   localparam logic [15:0] SSSR_ENA_RST = 16'h0000;
   localparam logic [7:0] SSSR_SRE_RST = 8'h00;
   localparam logic [15:0] SSSR_RD_RST = 16'h0000;
   // the error queue is told to empty for as long as reset is held
   localparam logic SSSR_ERRCLR_RST = 1'b1;

   // ----------------------------------------------------------------
   // event register set indices
   // ----------------------------------------------------------------
   typedef enum logic [3:0]
   {
      SSSR_SET_STD = 4'h0,
      SSSR_SET_OPER = 4'h1,
      SSSR_SET_OPER_INST = 4'h2,
      SSSR_SET_OPER_ISUM = 4'h3,
      SSSR_SET_QUES = 4'h4,
      SSSR_SET_QUES_INST = 4'h5,
      SSSR_SET_QUES_ISUM = 4'h6,
      SSSR_SET_MEAS = 4'h7,
      SSSR_SET_MEAS_INST = 4'h8,
      SSSR_SET_MEAS_ISUM = 4'h9
   } sssr_set_e;

   // ----------------------------------------------------------------
   // command port carriers
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic wr_ena;
      logic rd_evt;
      logic [3:0] sel;
      logic [15:0] data;
   } sssr_cmd_s;

   typedef struct packed
   {
      logic [3:0] sel;
      logic sel_ena;
   } sssr_rd_s;

   typedef struct packed
   {
      logic err_entry;
      logic msg_waiting;
   } sssr_queue_s;
endpackage

//--- sssr_event_set.sv
// one event register with its enable register and summary message
`timescale 1ns/10ps
module sssr_event_set
#(
   parameter int WIDTH = 16
)
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] evt_set,
   input wire logic evt_clr,
   input wire logic ena_wr,
   input wire logic [WIDTH-1:0] ena_data,
   output logic [WIDTH-1:0] evt_q,
   output logic [WIDTH-1:0] ena_q,
   output logic summary
);
   import sssr_pkg::*;

   typedef struct packed
   {
      logic [WIDTH-1:0] evt;
      logic [WIDTH-1:0] ena;
   } sssr_set_state_s;

   sssr_set_state_s st_q;
   sssr_set_state_s st_d;

   // the reset constants are only as wide as the widest event register
   if (WIDTH < 1 || WIDTH > SSSR_EVT_W)
   begin : g_bad_width
      $error("event set width out of range");
   end

   always_comb
   begin
      st_d = st_q;
      // new events win over a clear landing in the same cycle
      if (evt_clr)
      begin
         st_d.evt = '0;
      end
      st_d.evt = st_d.evt | evt_set;
      if (ena_wr)
      begin
         st_d.ena = ena_data;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         st_q.evt <= SSSR_EVT_RST[WIDTH-1:0];
         st_q.ena <= SSSR_ENA_RST[WIDTH-1:0];
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign evt_q = st_q.evt;
   assign ena_q = st_q.ena;
   // a cleared enable bit masks its event, a set one passes it
   assign summary = |(st_q.evt & st_q.ena);
endmodule

//--- sssr_status_summary.sv
// status summary byte and service request logic for the instrument
`timescale 1ns/10ps
module sssr_status_summary
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clear_status_command,
   input wire sssr_pkg::sssr_cmd_s cmd,
   input wire logic sre_wr,
   input wire logic [7:0] sre_data,
   input wire sssr_pkg::sssr_rd_s rd,
   input wire logic [sssr_pkg::SSSR_NUM_SETS*sssr_pkg::SSSR_EVT_W-1:0] evt_set,
   input wire sssr_pkg::sssr_queue_s queue,
   output logic [15:0] rd_data,
   output logic [7:0] status_summary_byte,
   output logic [7:0] sre_q_out,
   output logic error_queue_clear,
   output logic service_request_flag,
   output logic master_summary_flag
);
   import sssr_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [7:0] sre;
      logic [15:0] rd_data;
      logic err_clr;
   } sssr_top_state_s;

   sssr_top_state_s st_q;
   sssr_top_state_s st_d;

   logic [SSSR_NUM_SETS*SSSR_EVT_W-1:0] evt_all;
   logic [SSSR_NUM_SETS*SSSR_EVT_W-1:0] ena_all;
   logic [SSSR_NUM_SETS-1:0] summ;
   logic [SSSR_NUM_SETS-1:0] clr_vec;
   logic [SSSR_NUM_SETS-1:0] wr_vec;
   logic [7:0] sbyte;
   logic operation_summary_flag;
   logic questionable_summary_flag;
   logic standard_event_summary_flag;
   logic error_queue_nonempty_flag;
   logic response_waiting_flag;
   logic meas_summary_flag;

   function automatic logic sel_hit(input logic [3:0] sel, input int idx);
      sel_hit = (sel == 4'(idx));
   endfunction

   // a select past the last set names nothing; a read of it returns SSSR_RD_RST
   function automatic logic set_valid(input logic [3:0] sel);
      set_valid = (int'(sel) < SSSR_NUM_SETS);
   endfunction

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the set select is four bits wide, so no more than sixteen sets can be reached
   if (SSSR_NUM_SETS < 1 || SSSR_NUM_SETS > 16)
   begin : g_bad_sets
      $error("number of event sets out of range");
   end
   // the read port carries one event register per read
   if (SSSR_EVT_W < 1 || SSSR_EVT_W > 16)
   begin : g_bad_evt_w
      $error("event register width out of range");
   end
   if (SSSR_STD_W > SSSR_EVT_W)
   begin : g_bad_std_w
      $error("standard set wider than an event register");
   end
   // every summary bit must land inside the byte
   if (SSSR_BIT_MEAS > 7 || SSSR_BIT_ERR > 7 || SSSR_BIT_QUES > 7 || SSSR_BIT_MSG > 7)
   begin : g_bad_low_pos
      $error("summary bit position outside the byte");
   end
   if (SSSR_BIT_STD > 7 || SSSR_BIT_RQS > 7 || SSSR_BIT_OPER > 7 || SSSR_BIT_UNUSED > 7)
   begin : g_bad_high_pos
      $error("summary bit position outside the byte");
   end

   // ----------------------------------------------------------------
   // event register sets
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < SSSR_NUM_SETS; gi++)
      begin : g_set
         // a cmd.rd_evt read of the register clears it, a rd port read does not; clear-status clears all ten
         assign clr_vec[gi] = clear_status_command
                              | (cmd.rd_evt & sel_hit(cmd.sel, gi));
         assign wr_vec[gi] = cmd.wr_ena & sel_hit(cmd.sel, gi);
         sssr_event_set
         #(
            .WIDTH(SSSR_EVT_W)
         )
         u_set
         (
            .mclk(mclk),
            .rst_b(rst_b),
            .evt_set(evt_set[gi*SSSR_EVT_W +: SSSR_EVT_W]),
            .evt_clr(clr_vec[gi]),
            .ena_wr(wr_vec[gi]),
            .ena_data(cmd.data),
            .evt_q(evt_all[gi*SSSR_EVT_W +: SSSR_EVT_W]),
            .ena_q(ena_all[gi*SSSR_EVT_W +: SSSR_EVT_W]),
            .summary(summ[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // summary messages
   // ----------------------------------------------------------------
   // the standard set is built SSSR_EVT_W wide like the rest; its upper bits are not masked
   assign standard_event_summary_flag = summ[SSSR_SET_STD];
   assign operation_summary_flag = summ[SSSR_SET_OPER];
   assign questionable_summary_flag = summ[SSSR_SET_QUES];
   assign meas_summary_flag = summ[SSSR_SET_MEAS];
   assign error_queue_nonempty_flag = queue.err_entry;
   assign response_waiting_flag = queue.msg_waiting;

   // ----------------------------------------------------------------
   // summary byte
   // ----------------------------------------------------------------
   // combinational so no bit outlives its message
   always_comb
   begin
      sbyte = 8'h00;
      sbyte[SSSR_BIT_MEAS] = meas_summary_flag;
      sbyte[SSSR_BIT_UNUSED] = 1'b0;
      sbyte[SSSR_BIT_ERR] = error_queue_nonempty_flag;
      sbyte[SSSR_BIT_QUES] = questionable_summary_flag;
      sbyte[SSSR_BIT_MSG] = response_waiting_flag;
      sbyte[SSSR_BIT_STD] = standard_event_summary_flag;
      sbyte[SSSR_BIT_OPER] = operation_summary_flag;
      // the enable's own bit 6 is excluded so the summary cannot feed itself
      sbyte[SSSR_BIT_RQS] = |(sbyte & st_q.sre & ~(8'h01 << SSSR_BIT_RQS));
   end

   assign master_summary_flag = sbyte[SSSR_BIT_RQS];
   assign service_request_flag = sbyte[SSSR_BIT_RQS];
   assign status_summary_byte = sbyte;

   // ----------------------------------------------------------------
   // enable register, read port and error queue clear
   // ----------------------------------------------------------------
   always_comb
   begin
      st_d = st_q;
      st_d.err_clr = clear_status_command;
      if (sre_wr)
      begin
         st_d.sre = sre_data;
      end
      if (rd.sel_ena && set_valid(rd.sel))
      begin
         st_d.rd_data = evt_all[rd.sel*SSSR_EVT_W +: SSSR_EVT_W];
      end
      else if (rd.sel_ena)
      begin
         // reading off the end of the vector would hand back unknowns
         st_d.rd_data = SSSR_RD_RST;
      end
      else
      begin
         st_d.rd_data = 16'(sbyte);
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         st_q.sre <= SSSR_SRE_RST;
         st_q.rd_data <= SSSR_RD_RST;
         st_q.err_clr <= SSSR_ERRCLR_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign rd_data = st_q.rd_data;
   assign sre_q_out = st_q.sre;
   assign error_queue_clear = st_q.err_clr;
endmodule

//--- sssr_status_summary_props.sv
// assertions on the status summary block ports
`timescale 1ns/10ps
module sssr_status_summary_props
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clear_status_command,
   input wire sssr_pkg::sssr_cmd_s cmd,
   input wire logic sre_wr,
   input wire logic [7:0] sre_data,
   input wire sssr_pkg::sssr_rd_s rd,
   input wire logic [159:0] evt_set,
   input wire sssr_pkg::sssr_queue_s queue,
   input wire logic [15:0] rd_data,
   input wire logic [7:0] status_summary_byte,
   input wire logic [7:0] sre_q_out,
   input wire logic error_queue_clear,
   input wire logic service_request_flag,
   input wire logic master_summary_flag
);
   import sssr_pkg::*;
   logic [7:0] sb;
   assign sb = status_summary_byte;
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // a set in the same cycle would win over the clear, so only quiet cycles count
   sequence s_clr;
      clear_status_command && evt_set == '0;
   endsequence
   sequence s_rdclr;
      cmd.rd_evt && cmd.sel == 4'h0 && evt_set[15:0] == 16'h0000;
   endsequence
   unused_bit_a: assert property (!sb[1]) else $error("unused bit set");
   err_bit_a: assert property (sb[2] == queue.err_entry) else $error("error bit wrong");
   msg_bit_a: assert property (sb[4] == queue.msg_waiting) else $error("message bit wrong");
   req_bit_a: assert property (sb[6] == |({sb[7], sb[5:0]} & {sre_q_out[7], sre_q_out[5:0]}))
      else $error("request bit wrong");
   req_flags_a: assert property (service_request_flag == sb[6] && master_summary_flag == sb[6])
      else $error("request flags wrong");
   sre_write_a: assert property (sre_wr |=> sre_q_out == $past(sre_data)) else $error("enable write lost");
   status_clear_a: assert property (s_clr |=> (sb & 8'hA9) == 8'h00 && error_queue_clear)
      else $error("clear status failed");
   std_rdclr_a: assert property (s_rdclr |=> !sb[5]) else $error("read clear kept bit");
   rd_byte_a: assert property (!rd.sel_ena |=> rd_data == {8'h00, $past(sb)}) else $error("read value wrong");
   reset_state_a: assert property (disable iff (1'b0) !rst_b |=> sre_q_out == 8'h00 && error_queue_clear)
      else $error("reset state wrong");
endmodule

//--- sssr_ctrl_model.sv
// remote controller model that counts service requests
`timescale 1ns/10ps
module sssr_ctrl_model
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic service_request_flag,
   output int srq_seen
);
   logic last_q;
   always_ff @(posedge mclk)
   begin
      last_q <= service_request_flag;
      if (!rst_b)
         srq_seen <= 0;
      else if (service_request_flag && !last_q)
         srq_seen <= srq_seen + 1;
   end
endmodule

//--- sssr_status_summary_tb.sv
// self-checking testbench for the status summary block
`timescale 1ns/10ps
module sssr_status_summary_tb;
   import sssr_pkg::*;
   logic mclk = 0, rst_b = 0, clear_status_command = 0, sre_wr = 0;
   sssr_cmd_s cmd = '0;
   sssr_rd_s rd = '0;
   sssr_queue_s queue = '0;
   logic [7:0] sre_data = 8'h00;
   logic [159:0] evt_set = '0;
   logic [15:0] rd_data;
   logic [7:0] status_summary_byte, sre_q_out;
   logic error_queue_clear, service_request_flag, master_summary_flag;
   int fail_count = 0, checked = 0, cyc = 0, srq_seen;
   sssr_status_summary dut (.mclk(mclk), .rst_b(rst_b), .clear_status_command(clear_status_command), .cmd(cmd),
      .sre_wr(sre_wr), .sre_data(sre_data), .rd(rd), .evt_set(evt_set), .queue(queue), .rd_data(rd_data),
      .status_summary_byte(status_summary_byte), .sre_q_out(sre_q_out), .error_queue_clear(error_queue_clear),
      .service_request_flag(service_request_flag), .master_summary_flag(master_summary_flag));
   sssr_ctrl_model ctrl (.mclk(mclk), .rst_b(rst_b), .service_request_flag(service_request_flag),
      .srq_seen(srq_seen));
   initial forever #12.5 mclk = ~mclk;
   // whole run needs well under a thousand cycles
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fail_count++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic sb_chk(input logic [7:0] e);
      chk({8'h00, status_summary_byte}, {8'h00, e});
   endtask
   task automatic wr(input logic [3:0] s, input logic [15:0] v);
      cmd = '{1'b1, 1'b0, s, v};
      @(negedge mclk);
      cmd = '0;
      @(negedge mclk);
   endtask
   task automatic rc(input logic [3:0] s);
      cmd = '{1'b0, 1'b1, s, 16'h0000};
      @(negedge mclk);
      cmd = '0;
      @(negedge mclk);
   endtask
   task automatic ev(input int s, input logic [15:0] v);
      evt_set[16*s+:16] = v;
      @(negedge mclk);
      evt_set = '0;
      @(negedge mclk);
   endtask
   task automatic rdr(input logic [3:0] s, input logic [15:0] e);
      rd = '{s, 1'b1};
      @(negedge mclk);
      chk(rd_data, e);
   endtask
   task automatic sre(input logic [7:0] v);
      sre_wr = 1'b1;
      sre_data = v;
      @(negedge mclk);
      sre_wr = 1'b0;
      @(negedge mclk);
   endtask
   task automatic t_reset();
      for (int i = 0; i < 10; i++)
         rdr(i[3:0], 16'h0000);
      sb_chk(8'h00);
      chk({8'h00, sre_q_out}, 16'h0000);
      $display("test reset done");
   endtask
   task automatic t_map();
      // inst sets feed no byte bit: chaining is the caller's job
      int bp[10] = '{5, 7, -1, -1, 3, -1, -1, 0, -1, -1};
      logic [7:0] e;
      for (int i = 0; i < 10; i++)
      begin
         e = (bp[i] < 0) ? 8'h00 : 8'h01 << bp[i];
         wr(i[3:0], 16'h0000);
         ev(i, 16'h0001);
         sb_chk(8'h00);
         rdr(i[3:0], 16'h0001);
         wr(i[3:0], 16'h0001);
         sb_chk(e);
         rc(i[3:0]);
         rdr(i[3:0], 16'h0000);
      end
      $display("test map done");
   endtask
   task automatic t_std();
      ev(0, 16'h0081);
      wr(4'h0, 16'h0080);
      sb_chk(8'h20);
      wr(4'h0, 16'h0100);
      sb_chk(8'h00);
      wr(4'h0, 16'h0001);
      sb_chk(8'h20);
      rc(4'h0);
      sb_chk(8'h00);
      $display("test std done");
   endtask
   task automatic t_sre();
      int n;
      n = srq_seen;
      ev(7, 16'h0001);
      sre(8'h01);
      sb_chk(8'h41);
      chk({14'h0000, service_request_flag, master_summary_flag}, 16'h0003);
      rd = '0;
      @(negedge mclk);
      chk(rd_data, 16'h0041);
      sre(8'hFE);
      sb_chk(8'h01);
      chk(16'(srq_seen - n), 16'h0001);
      queue = '{1'b1, 1'b0};
      #1 sb_chk(8'h45);
      @(negedge mclk);
      queue = '{1'b0, 1'b1};
      #1 sb_chk(8'h51);
      @(negedge mclk);
      queue = '0;
      #1 sb_chk(8'h01);
      @(negedge mclk);
      sre(8'h00);
      chk({8'h00, sre_q_out}, 16'h0000);
      $display("test sre done");
   endtask
   task automatic t_clear();
      evt_set = {10{16'h0001}};
      @(negedge mclk);
      evt_set = '0;
      wr(4'hF, 16'h0000);
      sb_chk(8'hA9);
      rdr(4'hF, 16'h0000);
      clear_status_command = 1'b1;
      @(negedge mclk);
      clear_status_command = 1'b0;
      chk({15'h0000, error_queue_clear}, 16'h0001);
      sb_chk(8'h00);
      for (int i = 0; i < 10; i++)
         rdr(i[3:0], 16'h0000);
      ev(7, 16'h0001);
      sb_chk(8'h01);
      // a new event in the clearing cycle survives the clear
      clear_status_command = 1'b1;
      evt_set[16*7+:16] = 16'h0002;
      @(negedge mclk);
      clear_status_command = 1'b0;
      evt_set = '0;
      @(negedge mclk);
      rdr(4'h7, 16'h0002);
      rc(4'h7);
      $display("test clear done");
   endtask
   task automatic t_midrst();
      ev(7, 16'h0001);
      sre(8'h01);
      sb_chk(8'h41);
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      rst_b = 1'b1;
      chk({15'h0000, error_queue_clear}, 16'h0001);
      sb_chk(8'h00);
      chk({8'h00, sre_q_out}, 16'h0000);
      rdr(4'h7, 16'h0000);
      ev(7, 16'h0001);
      sb_chk(8'h00);
      rdr(4'h7, 16'h0001);
      rc(4'h7);
      $display("test midrst done");
   endtask
   task automatic report_and_stop();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (5) @(negedge mclk);
      rst_b = 1'b1;
      t_reset();
      t_map();
      t_std();
      t_sre();
      t_clear();
      t_midrst();
      report_and_stop();
   end
endmodule
bind sssr_status_summary sssr_status_summary_props u_props (.mclk(mclk), .rst_b(rst_b),
   .clear_status_command(clear_status_command), .cmd(cmd), .sre_wr(sre_wr), .sre_data(sre_data), .rd(rd),
   .evt_set(evt_set), .queue(queue), .rd_data(rd_data), .status_summary_byte(status_summary_byte),
   .sre_q_out(sre_q_out), .error_queue_clear(error_queue_clear), .service_request_flag(service_request_flag),
   .master_summary_flag(master_summary_flag));
